// ---- src/rsb_top.sv ----
// record sample buffer with host register port on the link clock
// assumes encoder and stream front end run on clk_sys_i; host holds link_req_i until done
// Contract
// RULE1: buffer holds 1024 recorded words of 16 bits between encoder and host.
// RULE2: fill count reports waiting words while recording; host may read that many.
// RULE3: a write into a full buffer discards everything and returns it to empty.
// RULE4: host should not start reading at fill count 768 or more.
// RULE5: ADPCM words become visible in whole blocks, 128 mono or 256 stereo.
// RULE6: host pausing ADPCM readout stops only on block boundaries.
// RULE7: host stores PCM words low byte first.
// RULE8: host stores ADPCM words high byte first.
// RULE9: ADPCM block byte 2 (and 6 stereo) is 0..88, byte 3 (and 7) zero.
// RULE10: host PCM header: format 1, align 2 or 4, 16 bits, little-endian.
// RULE11: host PCM header sizes: file minus 8, file minus 36, rate 2*Fs*C.
// RULE12: host ADPCM header: format 0x11, 4 bits, align 256/512, 505 samples, fact.
// RULE13: host ADPCM sizes: n*C*256+52, n*505, n*C*256.
// RULE14: host patches header sizes after recording of unknown length.
// RULE15: volume register writes are ignored during ADPCM encoding.
// RULE16: attenuation at 0xC045: high byte left, low right; low nibble 6 dB, high 0.5 dB.
// RULE17: recorded files fed through the stream input are played back.
// RULE18: stream playback applies no sample rate restriction.
// RULE19: each data port read pops one word; reading at zero returns undefined.
// RULE20: host starts recording through the record enable mode bit.
// RULE21: format bit 2 latched at start: 0 ADPCM, 1 linear PCM.
`timescale 1ns/1ns
`default_nettype none
`include "rsb_consts.svh"
module rsb_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic link_req_i,
  input wire rsb_pkg::rsb_req_s link_cmd_i,
  output logic link_done_o,
  output logic [15:0] link_rdata_o,
  input wire logic enc_valid_i,
  input wire logic [15:0] enc_data_i,
  input wire rsb_pkg::rsb_stream_s stream_i,
  output rsb_pkg::rsb_stream_s decode_o,
  output logic rec_active_o,
  output logic rec_pcm_o,
  output logic rec_stereo_o,
  output logic [15:0] vol_o,
  output rsb_pkg::rsb_atten_s atten_o
);
  // link domain
  rsb_pkg::rsb_link_e lstate_q;
  rsb_pkg::rsb_req_s lcmd_q;
  logic lreq_tgl_q;
  logic lack_seen_q;
  logic lack_sync;
  // system domain
  logic sreq_sync;
  logic sreq_seen_q;
  logic sack_tgl_q;
  logic [15:0] srdata_q;
  logic acc;
  logic [15:0] mem_q [0:`RSB_BUF_DEPTH-1];
  logic [9:0] wr_ptr_q;
  logic [9:0] rd_ptr_q;
  logic [10:0] count_q;
  logic [7:0] blk_pos_q;
  logic [15:0] mode_q;
  logic [15:0] vol_q;
  logic [15:0] atten_q;
  logic [15:0] chfmt_q;
  logic [15:0] ram_addr_q;
  logic pcm_q;
  logic stereo_q;
  logic adpcm;
  logic push;
  logic pop;
  logic clr;
  logic ovf;
  logic rec_start;
  logic [7:0] blk_last;
  logic [10:0] vis;
  logic [15:0] wr_word;
  logic rd_fill;
  logic wr_vol;
  logic wr_atten;

  function automatic logic [15:0] rsb_fix_hdr(input logic [15:0] w);
    logic [7:0] idx;
    idx = w[15:8];
    if (idx > `RSB_IDX_MAX) begin
      idx = `RSB_IDX_MAX;
    end
    return {idx, 8'h00};
  endfunction : rsb_fix_hdr

  function automatic logic [3:0] rsb_fine(input logic [3:0] f);
    return (f > `RSB_FINE_MAX) ? `RSB_FINE_MAX : f;
  endfunction : rsb_fine

  // link side: capture request, toggle to system, wait for returned toggle
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lstate_q <= rsb_pkg::RSB_L_IDLE;
      lcmd_q <= '0;
      lreq_tgl_q <= 1'b0;
      lack_seen_q <= 1'b0;
      link_rdata_o <= 16'h0000;
    end else begin
      unique case (lstate_q)
        rsb_pkg::RSB_L_IDLE: begin
          if (link_req_i) begin
            lcmd_q <= link_cmd_i;
            lreq_tgl_q <= ~lreq_tgl_q;
            lstate_q <= rsb_pkg::RSB_L_WAIT;
          end
        end
        rsb_pkg::RSB_L_WAIT: begin
          if (lack_sync != lack_seen_q) begin
            lack_seen_q <= lack_sync;
            link_rdata_o <= srdata_q;
            lstate_q <= rsb_pkg::RSB_L_DONE;
          end
        end
        rsb_pkg::RSB_L_DONE: begin
          if (!link_req_i) begin
            lstate_q <= rsb_pkg::RSB_L_IDLE;
          end
        end
      endcase
    end
  end

  assign link_done_o = (lstate_q == rsb_pkg::RSB_L_DONE);

  rsb_sync u_ack_sync (
    .clk_i(link_clk_i),
    .rst_i(rst_i),
    .d_i(sack_tgl_q),
    .q_o(lack_sync)
  );

  rsb_sync u_req_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(lreq_tgl_q),
    .q_o(sreq_sync)
  );

  // lcmd_q stands still from its toggle until the ack returns
  assign acc = sreq_sync ^ sreq_seen_q;
  assign adpcm = mode_q[`RSB_MODE_REC_BIT] && !pcm_q;
  assign blk_last = stereo_q ? `RSB_BLK_LAST_STEREO : `RSB_BLK_LAST_MONO;
  // RULE5: partial block hidden
  assign vis = adpcm ? 11'(count_q - {3'b000, blk_pos_q}) : count_q;
  assign push = enc_valid_i && mode_q[`RSB_MODE_REC_BIT];
  // RULE3: full buffer overflow
  assign ovf = push && (count_q == `RSB_CNT_FULL);
  // RULE19: one pop per read
  assign pop = acc && !lcmd_q.we && (lcmd_q.addr == `RSB_REG_DATA_PORT) && mode_q[`RSB_MODE_REC_BIT]
    && (vis != 11'h000);
  assign rd_fill = acc && !lcmd_q.we && (lcmd_q.addr == `RSB_REG_FILL);
  assign rec_start = acc && lcmd_q.we && (lcmd_q.addr == `RSB_REG_MODE) && lcmd_q.wdata[`RSB_MODE_REC_BIT]
    && !mode_q[`RSB_MODE_REC_BIT];
  assign clr = ovf || rec_start;
  // RULE15: volume frozen while encoding
  assign wr_vol = acc && lcmd_q.we && (lcmd_q.addr == `RSB_REG_VOL) && !adpcm;
  assign wr_atten = acc && lcmd_q.we && (lcmd_q.addr == `RSB_REG_RAM_DATA) && (ram_addr_q == `RSB_RAM_ATTEN);

  // RULE9: block header index clamped, padding zeroed
  always_comb begin
    wr_word = enc_data_i;
    if (adpcm && (blk_pos_q == `RSB_BLK_AUX_WORD0 || (stereo_q && blk_pos_q == `RSB_BLK_AUX_WORD1))) begin
      wr_word = rsb_fix_hdr(enc_data_i);
    end
  end

  // RULE1: sample storage
  always_ff @(posedge clk_sys_i) begin
    if (push && !ovf) begin
      mem_q[wr_ptr_q] <= wr_word;
    end
  end

  // RULE2: pointers and fill count
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= 10'h000;
      rd_ptr_q <= 10'h000;
      count_q <= 11'h000;
    end else if (clr) begin
      wr_ptr_q <= 10'h000;
      rd_ptr_q <= 10'h000;
      count_q <= 11'h000;
    end else begin
      if (push) begin
        wr_ptr_q <= 10'(wr_ptr_q + 10'h001);
      end
      if (pop) begin
        rd_ptr_q <= 10'(rd_ptr_q + 10'h001);
      end
      count_q <= 11'(count_q + {10'h000, push} - {10'h000, pop});
    end
  end

  // RULE5: position inside the current compression block
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      blk_pos_q <= 8'h00;
    end else if (clr || !adpcm) begin
      blk_pos_q <= 8'h00;
    end else if (push) begin
      blk_pos_q <= (blk_pos_q == blk_last) ? 8'h00 : 8'(blk_pos_q + 8'h01);
    end
  end

  // control registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= `RSB_MODE_RST;
      chfmt_q <= `RSB_CHFMT_RST;
      ram_addr_q <= 16'h0000;
      vol_q <= `RSB_VOL_RST;
      atten_q <= `RSB_ATTEN_RST;
      pcm_q <= 1'b0;
      stereo_q <= 1'b0;
    end else begin
      if (acc && lcmd_q.we && lcmd_q.addr == `RSB_REG_MODE) begin
        mode_q <= lcmd_q.wdata;
      end
      if (acc && lcmd_q.we && lcmd_q.addr == `RSB_REG_CHFMT) begin
        chfmt_q <= lcmd_q.wdata;
      end
      if (acc && lcmd_q.we && lcmd_q.addr == `RSB_REG_RAM_ADDR) begin
        ram_addr_q <= lcmd_q.wdata;
      end
      if (wr_vol) begin
        vol_q <= lcmd_q.wdata;
      end
      if (wr_atten) begin
        atten_q <= lcmd_q.wdata;
      end
      // RULE21: format latched at start
      if (rec_start) begin
        pcm_q <= chfmt_q[`RSB_CHFMT_PCM_BIT];
        stereo_q <= (chfmt_q[1:0] == 2'b00) || (chfmt_q[1:0] == 2'b01);
      end
    end
  end

  // read answers and return toggle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sreq_seen_q <= 1'b0;
      sack_tgl_q <= 1'b0;
      srdata_q <= 16'h0000;
    end else if (acc) begin
      sreq_seen_q <= sreq_sync;
      sack_tgl_q <= ~sack_tgl_q;
      if (!lcmd_q.we) begin
        unique case (lcmd_q.addr)
          `RSB_REG_MODE: srdata_q <= mode_q;
          `RSB_REG_CHFMT: srdata_q <= chfmt_q;
          `RSB_REG_RAM_ADDR: srdata_q <= ram_addr_q;
          `RSB_REG_VOL: srdata_q <= vol_q;
          `RSB_REG_RAM_DATA: srdata_q <= (ram_addr_q == `RSB_RAM_ATTEN) ? atten_q : 16'h0000;
          `RSB_REG_FILL: srdata_q <= mode_q[`RSB_MODE_REC_BIT] ? {5'h00, vis} : 16'h0000;
          `RSB_REG_DATA_PORT: srdata_q <= mode_q[`RSB_MODE_REC_BIT] ? mem_q[rd_ptr_q] : 16'h0000;
          default: srdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // RULE17: stream bytes go to the decoder
  // RULE18: no rate check applied
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      decode_o <= '0;
    end else begin
      decode_o <= stream_i;
    end
  end

  assign rec_active_o = mode_q[`RSB_MODE_REC_BIT];
  assign rec_pcm_o = pcm_q;
  assign rec_stereo_o = stereo_q;
  assign vol_o = vol_q;
  // RULE16: channel bytes and nibble steps
  assign atten_o.left_fine = rsb_fine(atten_q[15:12]);
  assign atten_o.left_coarse = atten_q[11:8];
  assign atten_o.right_fine = rsb_fine(atten_q[7:4]);
  assign atten_o.right_coarse = atten_q[3:0];

  sequence s_link_req;
    (lstate_q == rsb_pkg::RSB_L_IDLE) && link_req_i;
  endsequence
  sequence s_link_ans;
    ##[1:8] link_done_o;
  endsequence

  a_link_answer: assert property (@(posedge link_clk_i) disable iff (rst_i) s_link_req |-> s_link_ans) // RULE2
    else $error("link request not answered in time");
  a_overflow_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i) ovf |=> count_q == 11'h000) // RULE3
    else $error("overflow did not empty the buffer");
  a_pop_step: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE19
    pop && !push && !clr |=> count_q == 11'($past(count_q) - 11'h001))
    else $error("read did not remove one word");
  a_fill_value: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE2
    rd_fill && mode_q[`RSB_MODE_REC_BIT] |=> srdata_q == {5'h00, $past(vis)})
    else $error("fill count answer wrong");
  a_block_hidden: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE5
    adpcm && push && !clr && !pop && !(acc && lcmd_q.we) && blk_pos_q != blk_last |=> vis == $past(vis))
    else $error("partial block became visible");
  a_block_header: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE9
    adpcm && push && !ovf && blk_pos_q == `RSB_BLK_AUX_WORD0
    |=> mem_q[$past(wr_ptr_q)][7:0] == 8'h00 && mem_q[$past(wr_ptr_q)][15:8] <= `RSB_IDX_MAX)
    else $error("block header byte out of range");
  a_vol_frozen: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE15
    acc && lcmd_q.we && lcmd_q.addr == `RSB_REG_VOL && adpcm |=> $stable(vol_q))
    else $error("volume changed during encoding");
  a_atten_map: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE16
    wr_atten |=> atten_o.left_coarse == $past(lcmd_q.wdata[11:8])
      && atten_o.right_coarse == $past(lcmd_q.wdata[3:0]))
    else $error("attenuation bytes mapped wrong");
  a_format_latch: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE21
    rec_start |=> pcm_q == $past(chfmt_q[`RSB_CHFMT_PCM_BIT]))
    else $error("format not latched at start");
  a_stream_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE17
    stream_i.valid |=> decode_o.valid && decode_o.data == $past(stream_i.data))
    else $error("stream byte not passed to decoder");
endmodule : rsb_top
`default_nettype wire

// ---- src/rsb_consts.svh ----
// constants of the record sample buffer: register numbers, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef RSB_CONSTS_SVH
`define RSB_CONSTS_SVH
`define RSB_BUF_DEPTH 1024
`define RSB_CNT_FULL 11'h400
`define RSB_REG_MODE 4'h0
`define RSB_REG_RAM_DATA 4'h6
`define RSB_REG_RAM_ADDR 4'h7
`define RSB_REG_DATA_PORT 4'h8
`define RSB_REG_FILL 4'h9
`define RSB_REG_VOL 4'hB
`define RSB_REG_CHFMT 4'hF
`define RSB_RAM_ATTEN 16'hC045
`define RSB_MODE_REC_BIT 2
`define RSB_CHFMT_PCM_BIT 2
`define RSB_BLK_LAST_MONO 8'h7F
`define RSB_BLK_LAST_STEREO 8'hFF
`define RSB_BLK_AUX_WORD0 8'h01
`define RSB_BLK_AUX_WORD1 8'h03
`define RSB_IDX_MAX 8'h58
`define RSB_FINE_MAX 4'hB
`define RSB_MODE_RST 16'h0000
`define RSB_VOL_RST 16'h0000
`define RSB_ATTEN_RST 16'h0000
`define RSB_CHFMT_RST 16'h0000
`endif

// ---- src/rsb_pkg.sv ----
// types shared by the record sample buffer files
// assumes nothing beyond a SystemVerilog compiler
package rsb_pkg;
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [15:0] wdata;
  } rsb_req_s;
  typedef struct packed {
    logic [3:0] left_fine;
    logic [3:0] left_coarse;
    logic [3:0] right_fine;
    logic [3:0] right_coarse;
  } rsb_atten_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rsb_stream_s;
  typedef enum logic [1:0] {
    RSB_L_IDLE,
    RSB_L_WAIT,
    RSB_L_DONE
  } rsb_link_e;
endpackage : rsb_pkg

// ---- src/rsb_sync.sv ----
// two flip-flop synchroniser for one level
// assumes d_i is a level from a foreign clock domain
`timescale 1ns/1ns
`default_nettype none
module rsb_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : rsb_sync
`default_nettype wire

// ---- testbench/rsb_host_model.sv ----
// host model on the register link: one request at a time
// assumes the block answers with link_done_o within a few link clock cycles
`timescale 1ns/1ns
`default_nettype none
module rsb_host_model (
  input wire logic link_clk_i,
  input wire logic link_done_i,
  input wire logic [15:0] link_rdata_i,
  output logic link_req_o,
  output rsb_pkg::rsb_req_s link_cmd_o
);
  initial begin
    link_req_o = 1'b0;
    link_cmd_o = '0;
  end
  // file bytes of one data word, first byte in the upper half
  function automatic logic [15:0] file_bytes(input logic pcm, input logic [15:0] w);
    return pcm ? {w[7:0], w[15:8]} : w;
  endfunction : file_bytes
  // header field; n is file size for pcm, block count for adpcm
  function automatic logic [31:0] hdr_field(input logic pcm, input logic [1:0] ch, input logic [31:0] n,
                                            input logic [31:0] fs, input logic [2:0] sel);
    logic [31:0] c;
    c = {30'h0, ch};
    unique case (sel)
      3'h0: return pcm ? 32'h1 : 32'h11;
      3'h1: return pcm ? 32'(32'h2 * c) : 32'(c * 32'h100);
      3'h2: return pcm ? 32'h10 : 32'h4;
      3'h3: return pcm ? 32'(n - 32'h8) : 32'(n * c * 32'h100 + 32'h34);
      3'h4: return pcm ? 32'(n - 32'h24) : 32'(n * c * 32'h100);
      3'h5: return pcm ? 32'(32'h2 * fs * c) : 32'(n * 32'h1F9);
      3'h6: return pcm ? 32'h0 : 32'h1F9;
      default: return pcm ? 32'h0 : 32'h2;
    endcase
  endfunction : hdr_field
  // request held until done, then released
  task automatic xfer(input logic we, input logic [3:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic ok);
    int n;
    ok = 1'b0;
    rdata = 16'h0000;
    @(posedge link_clk_i);
    #1;
    link_cmd_o = '{we: we, addr: addr, wdata: wdata};
    link_req_o = 1'b1;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge link_clk_i);
      if (link_done_i === 1'b1) begin
        ok = 1'b1;
        rdata = link_rdata_i;
      end
    end
    #1;
    link_req_o = 1'b0;
    // released command shows no stale value
    link_cmd_o = ~link_cmd_o;
    repeat (2) @(posedge link_clk_i);
  endtask : xfer
endmodule : rsb_host_model
`default_nettype wire

// ---- testbench/rsb_top_tb.sv ----
// self-checking bench for the record sample buffer
// assumes the host model drives the link and the bench drives encoder and stream
`timescale 1ns/1ns
`default_nettype none
`include "rsb_consts.svh"
module rsb_top_tb;
  logic clk_sys_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_i = 1'b1;
  logic enc_valid = 1'b0;
  logic [15:0] enc_data = 16'h0000;
  rsb_pkg::rsb_stream_s stream = '0;
  rsb_pkg::rsb_stream_s decode;
  rsb_pkg::rsb_atten_s atten;
  rsb_pkg::rsb_req_s cmd;
  logic req, done, active, pcm, stereo;
  logic [15:0] rdata, vol;
  int err_count = 0;
  int cmp_count = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  rsb_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link_clk_i(link_clk), .link_req_i(req),
    .link_cmd_i(cmd), .link_done_o(done), .link_rdata_o(rdata), .enc_valid_i(enc_valid),
    .enc_data_i(enc_data), .stream_i(stream), .decode_o(decode), .rec_active_o(active),
    .rec_pcm_o(pcm), .rec_stereo_o(stereo), .vol_o(vol), .atten_o(atten));
  rsb_host_model host (.link_clk_i(link_clk), .link_done_i(done), .link_rdata_i(rdata),
    .link_req_o(req), .link_cmd_o(cmd));
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic we, input logic [3:0] a, input logic [15:0] wd, output logic [15:0] d);
    logic ok;
    host.xfer(we, a, wd, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [15:0] wd);
    logic [15:0] d;
    acc(1'b1, a, wd, d);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    acc(1'b0, a, 16'h0000, d);
    check(d, exp);
  endtask : rdc
  task automatic push(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      #1;
      enc_valid = 1'b1;
      enc_data = base + 16'(i);
    end
    @(posedge clk_sys_i);
    #1;
    enc_valid = 1'b0;
    enc_data = ~enc_data;
  endtask : push
  initial begin
    repeat (16) @(posedge clk_sys_i);
    repeat (3) @(posedge link_clk);
    @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check(atten, 16'h0000);
    rdc(`RSB_REG_FILL, 16'h0000);
    wr(`RSB_REG_VOL, 16'h2121);
    check(vol, 16'h2121);
    rdc(4'h3, 16'h0000);
    wr(`RSB_REG_CHFMT, 16'h0006);
    wr(`RSB_REG_MODE, 16'h0004);
    check({13'h0, active, pcm, stereo}, 16'h0006);
    push(5, 16'h1000);
    rdc(`RSB_REG_FILL, 16'h0005);
    for (int i = 0; i < 5; i++) begin
      rdc(`RSB_REG_DATA_PORT, 16'h1000 + 16'(i));
    end
    rdc(`RSB_REG_FILL, 16'h0000);
    push(1024, 16'h0000);
    rdc(`RSB_REG_FILL, 16'h0400);
    push(1, 16'h0000);
    rdc(`RSB_REG_FILL, 16'h0000);
    wr(`RSB_REG_MODE, 16'h0000);
    wr(`RSB_REG_CHFMT, 16'h0002);
    wr(`RSB_REG_MODE, 16'h0004);
    check({13'h0, active, pcm, stereo}, 16'h0004);
    wr(`RSB_REG_VOL, 16'h0E0E);
    check(vol, 16'h2121);
    push(127, 16'hFF54);
    rdc(`RSB_REG_FILL, 16'h0000);
    push(1, 16'hFFD3);
    rdc(`RSB_REG_FILL, 16'h0080);
    rdc(`RSB_REG_DATA_PORT, 16'hFF54);
    rdc(`RSB_REG_DATA_PORT, 16'h5800);
    rdc(`RSB_REG_FILL, 16'h007E);
    // host drains the whole block before pausing
    for (int i = 2; i < 128; i++) begin
      rdc(`RSB_REG_DATA_PORT, 16'hFF54 + 16'(i));
    end
    rdc(`RSB_REG_FILL, 16'h0000);
    wr(`RSB_REG_MODE, 16'h0000);
    wr(`RSB_REG_CHFMT, 16'h0001);
    wr(`RSB_REG_MODE, 16'h0004);
    check({13'h0, active, pcm, stereo}, 16'h0005);
    push(255, 16'h58FE);
    rdc(`RSB_REG_FILL, 16'h0000);
    push(1, 16'h59FD);
    rdc(`RSB_REG_FILL, 16'h0100);
    rdc(`RSB_REG_DATA_PORT, 16'h58FE);
    rdc(`RSB_REG_DATA_PORT, 16'h5800);
    rdc(`RSB_REG_DATA_PORT, 16'h5900);
    rdc(`RSB_REG_DATA_PORT, 16'h5800);
    // readout ends with the recording, mid-block after 4 of the 256 words
    wr(`RSB_REG_MODE, 16'h0000);
    rdc(`RSB_REG_FILL, 16'h0000);
    // monitoring level through attenuation, fine nibble above range
    wr(`RSB_REG_RAM_ADDR, `RSB_RAM_ATTEN);
    wr(`RSB_REG_RAM_DATA, 16'hC3B1);
    check(atten, 16'hB3B1);
    rdc(`RSB_REG_RAM_DATA, 16'hC3B1);
    @(posedge clk_sys_i);
    #1;
    stream = '{valid: 1'b1, data: 8'hA5};
    @(posedge clk_sys_i);
    #1;
    stream = '{valid: 1'b0, data: 8'h5A};
    check(16'(decode), 16'h01A5);
    @(posedge clk_sys_i);
    #1;
    check(16'(decode), 16'h005A);
    // host file building: byte order and headers patched with final lengths
    check(host.file_bytes(1'b1, 16'h1004), 16'h0410);
    check(host.file_bytes(1'b0, 16'h2A11), 16'h2A11);
    check(host.hdr_field(1'b1, 2'h1, 32'h001B7270, 32'h0000AC44, 3'h0), 32'h00000001);
    check(host.hdr_field(1'b1, 2'h1, 32'h001B7270, 32'h0000AC44, 3'h1), 32'h00000002);
    check(host.hdr_field(1'b1, 2'h1, 32'h001B7270, 32'h0000AC44, 3'h2), 32'h00000010);
    check(host.hdr_field(1'b1, 2'h1, 32'h001B7270, 32'h0000AC44, 3'h3), 32'h001B7268);
    check(host.hdr_field(1'b1, 2'h1, 32'h001B7270, 32'h0000AC44, 3'h4), 32'h001B724C);
    check(host.hdr_field(1'b1, 2'h1, 32'h001B7270, 32'h0000AC44, 3'h5), 32'h00015888);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h0), 32'h00000011);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h1), 32'h00000200);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h2), 32'h00000004);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h3), 32'h00000634);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h4), 32'h00000600);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h5), 32'h000005EB);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h6), 32'h000001F9);
    check(host.hdr_field(1'b0, 2'h2, 32'h00000003, 32'h00000000, 3'h7), 32'h00000002);
    stop_test();
  end
endmodule : rsb_top_tb
`default_nettype wire
